// ### verilog/ppoc_top.sv
// Downstream port power control and overcurrent sense for a hub
//
// Overview of operation
// [R1] One pin drives power, senses overcurrent
// [R2] Ganged or individual port control modes
// [R3] Ganged mode only from stored configuration
// [R4] Shared pin controls all ports when ganged
// [R5] Shared overcurrent flags every port
// [R6] Individual mode is the reset default
// [R7] Power off: drive low, pull-up off
// [R8] Power on: release driver, pull-up on
// [R9] Switch pulls pin low on fault
// [R10] Low while powered is overcurrent candidate
// [R11] Filter transient lows on power up
// [R12] Per-port charging supply indication
// [R13] Reset restores all defaults
// [R14] Sample pin continuously while enabled
// [R15] Continuous low for pulse width
// [R16] Two low groupings within window
// [R17] Ignore sense during turn-on lockout
// [R18] Sticky flag plus event to controller
// [R19] Prescaled ms timing, synchronised pins
`timescale 1ns/100ps
`default_nettype none
module ppoc_top #(
  parameter int NPORTS = ppoc_pkg::PPOC_NPORTS,
  parameter int MS_CYCLES = ppoc_pkg::PPOC_MS_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Stored configuration
  input wire logic gang_mode_cfg,
  input wire ppoc_pkg::ppoc_ocs_cfg_t ocs_cfg,
  input wire logic [NPORTS-1:0] bc_supply_cfg,
  // Hub control
  input wire logic [NPORTS-1:0] port_pwr_en,
  input wire logic [NPORTS-1:0] oc_clear,
  // Per-port control and sense pins
  input wire logic [NPORTS-1:0] port_power_sense_pins_in,
  output logic [NPORTS-1:0] port_power_sense_pins_out_q,
  output logic [NPORTS-1:0] port_power_sense_pins_oe_q,
  output logic [NPORTS-1:0] port_power_sense_pins_pu_q,
  // Shared ganged pin
  input wire logic shared_power_sense_pin_in,
  output logic shared_power_sense_pin_out_q,
  output logic shared_power_sense_pin_oe_q,
  output logic shared_power_sense_pin_pu_q,
  // Status
  output logic gang_mode_q,
  output logic [NPORTS-1:0] oc_flag_q,
  output logic [NPORTS-1:0] oc_event_q,
  output logic [NPORTS-1:0] bc_supply_ind_q
);
  import ppoc_pkg::*;

  logic cfg_done_q;           // Mode captured after reset
  logic [31:0] pre_q;         // Millisecond prescaler
  logic ms_tick_q;            // One-cycle millisecond tick
  logic [NPORTS:0] chan_pwr;  // Power on per filter channel
  logic [NPORTS:0] chan_raw;  // Raw pin per filter channel
  logic [NPORTS:0] chan_det;  // Detection per filter channel
  logic [NPORTS-1:0] oc_set;  // Flag set per port
  logic [NPORTS-1:0] pwr_eff; // Port powered in the current mode
  logic shared_power_sense_pin;             // Shared pin powered

  // [R3] [R6] mode captured once after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_done_q <= 1'b0;
      gang_mode_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      gang_mode_q <= gang_mode_cfg;
    end
  end

  // [R19] millisecond prescaler
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_q <= 32'h0000_0000;
      ms_tick_q <= 1'b0;
    end else if (pre_q == 32'(MS_CYCLES - 1)) begin
      pre_q <= 32'h0000_0000;
      ms_tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
      ms_tick_q <= 1'b0;
    end
  end

  // [R4] shared pin powered while ganged and any port is on
  assign shared_power_sense_pin = gang_mode_q && (|port_pwr_en);
  assign pwr_eff = gang_mode_q ? {NPORTS{shared_power_sense_pin}} : port_pwr_en;

  // [R2] one filter per port pin plus the shared pin
  genvar gi;
  generate
    for (gi = 0; gi <= NPORTS; gi++) begin : g_chan
      if (gi < NPORTS) begin : g_port
        assign chan_pwr[gi] = !gang_mode_q && port_pwr_en[gi];
        assign chan_raw[gi] = port_power_sense_pins_in[gi];
      end else begin : g_shared
        assign chan_pwr[gi] = shared_power_sense_pin;
        assign chan_raw[gi] = shared_power_sense_pin_in;
      end
      ppoc_ocs_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .ms_tick(ms_tick_q),
        .pwr_on(chan_pwr[gi]),
        .sense_raw(chan_raw[gi]),
        .cfg(ocs_cfg),
        .oc_det_q(chan_det[gi])
      );
    end
  endgenerate

  // [R5] shared detection flags every port
  assign oc_set = gang_mode_q ? {NPORTS{chan_det[NPORTS]}}
                              : chan_det[NPORTS-1:0];

  // [R1] [R7] [R8] open-drain pin control
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_power_sense_pins_out_q <= '0;
      port_power_sense_pins_oe_q <= '1;
      port_power_sense_pins_pu_q <= '0;
      shared_power_sense_pin_out_q <= 1'b0;
      shared_power_sense_pin_oe_q <= 1'b1;
      shared_power_sense_pin_pu_q <= 1'b0;
    end else begin
      port_power_sense_pins_out_q <= '0;
      port_power_sense_pins_oe_q <= ~chan_pwr[NPORTS-1:0];
      port_power_sense_pins_pu_q <= chan_pwr[NPORTS-1:0];
      shared_power_sense_pin_out_q <= 1'b0;
      shared_power_sense_pin_oe_q <= !shared_power_sense_pin;
      shared_power_sense_pin_pu_q <= shared_power_sense_pin;
    end
  end

  // [R13] [R18] sticky flags, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oc_flag_q <= '0;
      oc_event_q <= '0;
    end else begin
      oc_flag_q <= oc_set | (oc_flag_q & ~oc_clear);
      oc_event_q <= oc_set;
    end
  end

  // [R12] charging supply indication per port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bc_supply_ind_q <= '0;
    end else begin
      bc_supply_ind_q <= bc_supply_cfg & pwr_eff;
    end
  end

  // Powered-off port pin is driven low without pull-up
  property p_off_drive;
    @(posedge mclk) disable iff (!rst_n)
    (!gang_mode_q && !port_pwr_en[0]) |=>
      (port_power_sense_pins_oe_q[0] && !port_power_sense_pins_pu_q[0]
       && !port_power_sense_pins_out_q[0]);
  endproperty
  a_off_drive: assert property (p_off_drive) // [R7]
    else $error("Off port pin not driven low");

  // Powered port pin is released with pull-up
  property p_on_release;
    @(posedge mclk) disable iff (!rst_n)
    (!gang_mode_q && port_pwr_en[0]) |=>
      (!port_power_sense_pins_oe_q[0] && port_power_sense_pins_pu_q[0]);
  endproperty
  a_on_release: assert property (p_on_release) // [R8]
    else $error("On port pin not released");

  // Shared pin tracks ganged power
  property p_gang_pin;
    @(posedge mclk) disable iff (!rst_n)
    (gang_mode_q && (|port_pwr_en)) |=>
      (!shared_power_sense_pin_oe_q && shared_power_sense_pin_pu_q
       && (&port_power_sense_pins_oe_q));
  endproperty
  a_gang_pin: assert property (p_gang_pin) // [R4]
    else $error("Shared pin not controlling ports");

  // Shared detection sets every flag next cycle
  property p_gang_all;
    @(posedge mclk) disable iff (!rst_n)
    (gang_mode_q && chan_det[NPORTS]) |=> (&oc_flag_q && &oc_event_q);
  endproperty
  a_gang_all: assert property (p_gang_all) // [R5]
    else $error("Ganged overcurrent not on all ports");

  // Flag holds until cleared
  property p_sticky;
    @(posedge mclk) disable iff (!rst_n)
    (oc_flag_q[0] && !oc_clear[0]) |=> oc_flag_q[0];
  endproperty
  a_sticky: assert property (p_sticky) // [R18]
    else $error("Overcurrent flag dropped");

  // Mode never changes once captured
  property p_mode_fixed;
    @(posedge mclk) disable iff (!rst_n)
    cfg_done_q |=> $stable(gang_mode_q);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) // [R3]
    else $error("Port mode changed at run time");

  // Reset returns flags and mode to defaults
  property p_reset_dflt;
    @(posedge mclk)
    !rst_n |=> (oc_flag_q == '0 && !gang_mode_q && !cfg_done_q
                && port_power_sense_pins_oe_q == '1);
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) // [R13]
    else $error("Reset left non-default state");

  // Charging indication needs config and power
  property p_bc_ind;
    @(posedge mclk) disable iff (!rst_n)
    bc_supply_ind_q[0] |-> ($past(bc_supply_cfg[0]) && $past(pwr_eff[0]));
  endproperty
  a_bc_ind: assert property (p_bc_ind) // [R12]
    else $error("Charging indication without cause");

  // Tick is one cycle wide, never two in a row
  property p_tick;
    @(posedge mclk) disable iff (!rst_n)
    ms_tick_q |=> !ms_tick_q;
  endproperty
  a_tick: assert property (p_tick) // [R19]
    else $error("Millisecond tick too wide");
endmodule
`default_nettype wire

// ### verilog/ppoc_pkg.sv
// Package with constants and types for port power and overcurrent control
package ppoc_pkg;
  // Core clock period and one millisecond in nanoseconds
  localparam int PPOC_CLK_NS = 10;
  localparam int PPOC_MS_NS = 1_000_000;
  // Core clock cycles in one millisecond
  localparam int PPOC_MS_CYCLES = PPOC_MS_NS / PPOC_CLK_NS;
  // Number of downstream ports
  localparam int PPOC_NPORTS = 6;
  // Field widths of the timing configuration
  localparam int PPOC_WIDTH_W = 4;
  localparam int PPOC_TIMER_W = 8;
  // Default single pulse width, 5 ms
  localparam logic [3:0] PPOC_WIDTH_RST = 4'h5;
  // Default double pulse window, 20 ms
  localparam logic [7:0] PPOC_WINDOW_RST = 8'h14;
  // Default turn-on lockout, 10 ms
  localparam logic [7:0] PPOC_LOCKOUT_RST = 8'h0A;
  // Largest value of the low-run millisecond counter
  localparam logic [3:0] PPOC_LOW_MAX = 4'hF;

  // Overcurrent filter timing, all in milliseconds
  typedef struct packed {
    logic [3:0] min_width;  // Single low pulse width
    logic [7:0] dbl_window; // Double pulse window
    logic [7:0] lockout;    // Ignore time after power on
  } ppoc_ocs_cfg_t;

  // Default timing set
  localparam ppoc_ocs_cfg_t PPOC_OCS_CFG_RST =
    '{PPOC_WIDTH_RST, PPOC_WINDOW_RST, PPOC_LOCKOUT_RST};
endpackage

// ### verilog/ppoc_ocs_filter.sv
// Overcurrent sense filter for one control and sense pin
`timescale 1ns/100ps
`default_nettype none
module ppoc_ocs_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Millisecond tick from the prescaler
  input wire logic ms_tick,
  // Port power is on for this pin
  input wire logic pwr_on,
  // Raw pin level, asynchronous
  input wire logic sense_raw,
  // Timing configuration
  input wire ppoc_pkg::ppoc_ocs_cfg_t cfg,
  // One-cycle overcurrent detection
  output logic oc_det_q
);
  import ppoc_pkg::*;

  logic s1_q, s2_q, s3_q; // Pin synchroniser stages
  logic lvl_q;            // Filtered pin level
  logic pwr_q;            // Power state last cycle
  logic [7:0] lock_q;     // Lockout ms remaining
  logic [3:0] low_ms_q;   // Length of current low run
  logic low_prev_q;       // Low qualifier last cycle
  logic win_q;            // Double pulse window running
  logic [7:0] win_ms_q;   // Elapsed window time
  logic hold_q;           // Detection already given for this low
  logic low;              // Qualified low sample
  logic start;            // Start of a low grouping
  logic single_hit;
  logic dbl_hit;

  // [R19] pin synchronised
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= sense_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Level moves once the last two stages agree
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  // [R17] turn-on lockout
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_q <= 1'b0;
      lock_q <= 8'h00;
    end else begin
      pwr_q <= pwr_on;
      if (!pwr_on) begin
        lock_q <= 8'h00;
      end else if (!pwr_q) begin
        lock_q <= cfg.lockout;
      end else if (ms_tick && lock_q != 8'h00) begin
        lock_q <= lock_q - 8'h01;
      end
    end
  end

  // [R10] [R14] low sampled while enabled
  assign low = pwr_on && pwr_q && lock_q == 8'h00 && !lvl_q;
  assign start = low && !low_prev_q;
  // [R15] continuous low width
  assign single_hit = low && low_ms_q >= cfg.min_width;
  // [R16] second grouping in window
  assign dbl_hit = start && win_q;

  // Low-run length in milliseconds
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_ms_q <= 4'h0;
      low_prev_q <= 1'b0;
    end else begin
      low_prev_q <= low;
      if (!low) begin
        low_ms_q <= 4'h0;
      end else if (ms_tick && low_ms_q != PPOC_LOW_MAX) begin
        low_ms_q <= low_ms_q + 4'h1;
      end
    end
  end

  // [R16] double pulse window, opened by a grouping while closed
  always_ff @(posedge mclk) begin
    if (!rst_n || !pwr_on) begin
      win_q <= 1'b0;
      win_ms_q <= 8'h00;
    end else if (start && !win_q) begin
      win_q <= 1'b1;
      win_ms_q <= 8'h00;
    end else if (win_q && ms_tick) begin
      // Window closes when its time is spent
      if (win_ms_q + 8'h01 >= cfg.dbl_window) begin
        win_q <= 1'b0;
      end
      win_ms_q <= win_ms_q + 8'h01;
    end
  end

  // [R11] one detection per low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      oc_det_q <= 1'b0;
    end else begin
      oc_det_q <= (single_hit || dbl_hit) && !hold_q;
      if (!low) begin
        hold_q <= 1'b0;
      end else if (single_hit || dbl_hit) begin
        hold_q <= 1'b1;
      end
    end
  end

  // No detection during lockout
  property p_lockout_quiet;
    @(posedge mclk) disable iff (!rst_n)
    (lock_q != 8'h00) |=> !oc_det_q;
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet) // [R17]
    else $error("Detection during lockout");

  // Power-on edge seen by the filter
  sequence s_pwr_rise;
    pwr_on && !pwr_q;
  endsequence

  // Lockout count loads on the power-on edge
  property p_lock_load;
    @(posedge mclk) disable iff (!rst_n)
    s_pwr_rise |=> (lock_q == $past(cfg.lockout));
  endproperty
  a_lock_load: assert property (p_lock_load) // [R17]
    else $error("Lockout not loaded at power on");

  // Detection needs a qualified low just before
  property p_det_cause;
    @(posedge mclk) disable iff (!rst_n)
    oc_det_q |-> $past(low);
  endproperty
  a_det_cause: assert property (p_det_cause) // [R10]
    else $error("Detection without low sample");

  // A high on the pin clears the low run
  property p_high_resets;
    @(posedge mclk) disable iff (!rst_n)
    (pwr_on && lvl_q) |=> (low_ms_q == 4'h0);
  endproperty
  a_high_resets: assert property (p_high_resets) // [R15]
    else $error("Low run kept across a high");
endmodule
`default_nettype wire

// ### sim/ppoc_switch_model.sv
// Behavioural external power switch answering each control and sense pin
`timescale 1ns/100ps
`default_nettype none
module ppoc_switch_model #(
  parameter int N = 7
) (
  // Pin drive from the hub block
  input wire logic [N-1:0] drv_out,
  input wire logic [N-1:0] drv_oe,
  input wire logic [N-1:0] drv_pu,
  // Fault request per switch
  input wire logic [N-1:0] fault,
  // Resolved pin levels
  output logic [N-1:0] pin
);
  // Level of an undriven pin, flips so nothing can lean on it
  logic float_q = 1'b0;

  // Toggle the floating level
  always #3 float_q = ~float_q;

  // Resolve each wire from every party driving it
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (drv_oe[i]) pin[i] = drv_out[i];
      else if (fault[i] && drv_pu[i]) pin[i] = 1'b0;
      else if (drv_pu[i]) pin[i] = 1'b1;
      else pin[i] = float_q;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_ppoc_top.sv
// Self-checking testbench for port power and overcurrent control
`timescale 1ns/100ps
`default_nettype none
module tb_ppoc_top;
  import ppoc_pkg::*;
  // Short millisecond keeps the run brief
  localparam int NP = PPOC_NPORTS;
  localparam int MSC = 20;
  // Stimulus
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic gang_mode_cfg = 1'b0;
  ppoc_ocs_cfg_t ocs_cfg = '{4'h0, 8'h04, 8'h02};
  logic [NP-1:0] bc_supply_cfg = 6'h05;
  logic [NP-1:0] port_pwr_en = 6'h00;
  logic [NP-1:0] oc_clear = 6'h00;
  logic [NP:0] fault = 7'h00;
  // Pin wires and design outputs
  wire logic [NP:0] pins;
  logic [NP-1:0] pin_out;
  logic [NP-1:0] pin_oe;
  logic [NP-1:0] pin_pu;
  logic sh_out;
  logic sh_oe;
  logic sh_pu;
  logic gang_mode_q;
  logic [NP-1:0] oc_flag_q;
  logic [NP-1:0] oc_event_q;
  logic [NP-1:0] bc_supply_ind_q;
  // Score
  int bad_count = 0;
  int n_checks = 0;

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  ppoc_top #(.NPORTS(NP), .MS_CYCLES(MSC)) dut_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .gang_mode_cfg(gang_mode_cfg),
    .ocs_cfg(ocs_cfg),
    .bc_supply_cfg(bc_supply_cfg),
    .port_pwr_en(port_pwr_en),
    .oc_clear(oc_clear),
    .port_power_sense_pins_in(pins[NP-1:0]),
    .port_power_sense_pins_out_q(pin_out),
    .port_power_sense_pins_oe_q(pin_oe),
    .port_power_sense_pins_pu_q(pin_pu),
    .shared_power_sense_pin_in(pins[NP]),
    .shared_power_sense_pin_out_q(sh_out),
    .shared_power_sense_pin_oe_q(sh_oe),
    .shared_power_sense_pin_pu_q(sh_pu),
    .gang_mode_q(gang_mode_q),
    .oc_flag_q(oc_flag_q),
    .oc_event_q(oc_event_q),
    .bc_supply_ind_q(bc_supply_ind_q)
  );

  // Switches on every port pin plus the shared pin
  ppoc_switch_model #(.N(NP + 1)) sw_u (
    .drv_out({sh_out, pin_out}),
    .drv_oe({sh_oe, pin_oe}),
    .drv_pu({sh_pu, pin_pu}),
    .fault(fault),
    .pin(pins)
  );

  // Advance n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Compare a per-port vector
  task automatic chk_vec(input logic [NP-1:0] got, input logic [NP-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a single bit
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait up to lim edges for an event, check its one-cycle width and flags
  task automatic wait_flag(input logic [NP-1:0] exp, input int lim);
    int k;
    k = 0;
    while (oc_event_q === 6'h00 && k < lim) begin
      tick(1);
      k++;
    end
    chk_vec(oc_event_q, exp);
    tick(1);
    chk_vec(oc_event_q, 6'h00);
    chk_vec(oc_flag_q, exp);
  endtask

  // Pulse the flag clear for all ports
  task automatic clear_all();
    oc_clear = 6'h3F;
    tick(1);
    oc_clear = 6'h00;
    tick(2);
  endtask

  // Hold reset for 16 edges with the given mode strap
  task automatic do_reset(input logic gang);
    rst_n = 1'b0;
    gang_mode_cfg = gang;
    tick(16);
    rst_n = 1'b1;
    tick(2);
  endtask

  // Print the verdict and stop
  task automatic test_done();
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  // Main sequence
  initial begin
    #1;
    do_reset(1'b0);
    chk_bit(gang_mode_q, 1'b0);
    chk_vec(pin_oe, 6'h3F);
    chk_vec(pin_pu, 6'h00);
    chk_vec(pin_out, 6'h00);
    // Power port 0 with a fault already low; lockout must hide it
    port_pwr_en = 6'h01;
    fault[0] = 1'b1;
    tick(1);
    chk_vec(pin_oe, 6'h3E);
    chk_vec(pin_pu, 6'h01);
    tick(1);
    chk_vec(bc_supply_ind_q, 6'h01);
    tick(10);
    fault[0] = 1'b0;
    tick(150);
    chk_vec(oc_flag_q, 6'h00);
    // Continuous low must last the programmed width
    ocs_cfg.min_width = 4'h2;
    fault[0] = 1'b1;
    tick(15);
    chk_vec(oc_flag_q, 6'h00);
    wait_flag(6'h01, 300);
    fault[0] = 1'b0;
    tick(2);
    chk_vec(oc_flag_q, 6'h01);
    clear_all();
    chk_vec(oc_flag_q, 6'h00);
    tick(150);
    // Two short lows inside the window
    fault[0] = 1'b1;
    tick(8);
    fault[0] = 1'b0;
    tick(10);
    fault[0] = 1'b1;
    // Second grouping must be caught well before the width runs out
    wait_flag(6'h01, 12);
    fault[0] = 1'b0;
    clear_all();
    // Power off drives the pin low again
    port_pwr_en = 6'h00;
    tick(1);
    chk_vec(pin_oe, 6'h3F);
    chk_vec(pin_pu, 6'h00);
    tick(1);
    chk_vec(bc_supply_ind_q, 6'h00);
    // Ganged mode from the configuration strap
    do_reset(1'b1);
    gang_mode_cfg = 1'b0;
    tick(1);
    chk_bit(gang_mode_q, 1'b1);
    port_pwr_en = 6'h04;
    tick(1);
    chk_bit(sh_pu, 1'b1);
    chk_bit(sh_oe, 1'b0);
    chk_vec(pin_oe, 6'h3F);
    chk_bit(sh_out, 1'b0);
    chk_vec(bc_supply_ind_q, 6'h05);
    tick(60);
    fault[NP] = 1'b1;
    wait_flag(6'h3F, 300);
    fault[NP] = 1'b0;
    // Reset in mid-run clears every flag and drives the shared pin low without pull-up
    rst_n = 1'b0;
    tick(1);
    chk_vec(oc_flag_q, 6'h00);
    chk_bit(sh_oe, 1'b1);
    chk_bit(sh_pu, 1'b0);
    tick(15);
    rst_n = 1'b1;
    tick(2);
    chk_bit(gang_mode_q, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
